// file: core/rsfb_consts.svh
// Constants of the regenerator section frame source.
//
// Behaviour
// RQ1 - Output is byte stream, framed, clock alongside.
// RQ2 - Upstream fills payload and channel bytes.
// RQ3 - Orderwire, user, management bytes pass unchanged.
// RQ4 - Reserved row 2/3 bytes carry no content.
// RQ5 - Reserved row-1 bytes fixed, unscrambled, run-free.
// RQ6 - Operator row-1 bytes fixed, unscrambled, run-free.
// RQ7 - Alignment bytes written at start of row one.
// RQ8 - Trace byte taken from management input.
// RQ9 - Eight-bit interleaved parity, even sense.
// RQ10 - Parity of prior scrambled frame, inserted pre-scramble.
// RQ11 - Frame-synchronous scrambler, sequence length 127.
// RQ12 - Generator polynomial one plus X6 plus X7.
// RQ13 - Scrambler preset all ones at column 37.
// RQ14 - Each bit XORed with seventh stage output.
// RQ15 - Scrambler runs on; earlier row-1 bytes plain.
// RQ16 - Parity bit n covers bit n of bytes.
// RQ17 - Nine rows of 1080; fixed overhead layout.
// RQ18 - Alignment values are f6 and 28 hex.
// RQ19 - Output timing follows input with fixed latency.
`ifndef RSFB_CONSTS_SVH
`define RSFB_CONSTS_SVH
`define RSFB_FRAME_TIME_US  125
`define RSFB_ROWS           4'h9
`define RSFB_COLS           11'h438
`define RSFB_COL_A2         11'h00c
`define RSFB_COL_TRACE      11'h018
`define RSFB_COL_RSV        11'h019
`define RSFB_COL_OPER       11'h01c
`define RSFB_COL_SCR        11'h024
`define RSFB_ROW_PARITY     4'h1
`define RSFB_COL_PARITY     11'h000
`define RSFB_COL_ORDER      11'h00c
`define RSFB_COL_USER       11'h018
`define RSFB_FIRST_ALIGN    8'hf6
`define RSFB_SECOND_ALIGN   8'h28
`define RSFB_FILL_BYTE      8'h55
`define RSFB_SCR_PRESET     7'h7f
`define RSFB_CLK_DELAY      3'h4
`endif

// file: core/rsfb_pkg.sv
// Types shared by the regenerator section frame source.
package rsfb_pkg;
   // A byte of the stream together with its frame-start flag.
   typedef struct packed {
      logic       start;
      logic [7:0] data;
   } rsfb_byte_t;
   // Position of a byte in the frame, counted from zero.
   typedef struct packed {
      logic [3:0]  row;
      logic [10:0] col;
   } rsfb_pos_t;
endpackage : rsfb_pkg

// file: core/rsfb_frame_source.sv
// Regenerator section frame source: alignment, trace, parity and scrambling.
`include "rsfb_consts.svh"

module rsfb_frame_source (
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic       ADAPTED_FRAME_CLOCK,
   input  wire logic [7:0] ADAPTED_FRAME_DATA,
   input  wire logic       ADAPTED_FRAME_START,
   input  wire logic [7:0] MGMT_TX_TRACE_ID,
   output logic            LINE_FRAME_CLOCK,
   output logic [7:0]      LINE_FRAME_DATA,
   output logic            LINE_FRAME_START
);

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------

   // Advances the scrambler over one byte, most significant bit first.
   function automatic logic [14:0] scr_byte(input logic [6:0] s,
                                            input logic [7:0] d);
      logic [6:0] st;
      logic [7:0] q;
      st = s;
      q  = 8'h00;
      for (int i = 7; i >= 0; i--) begin
         q[i] = d[i] ^ st[6];                  // [RQ14]
         st   = {st[5:0], st[6] ^ st[5]};      // [RQ12] [RQ11]
      end
      return {st, q};
   endfunction : scr_byte

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------

   rsfb_pkg::rsfb_byte_t in_s1_reg;
   rsfb_pkg::rsfb_byte_t in_s2_reg;
   logic                 ck_s1_reg;
   logic                 ck_s2_reg;
   logic                 ck_s3_reg;
   logic [7:0]           tr_s1_reg;
   logic [7:0]           tr_s2_reg;

   // Two flip-flops on every pin before any logic reads it.
   // Data and start are held a whole link period, so they are settled when taken.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         in_s1_reg <= '0;
         in_s2_reg <= '0;
         ck_s1_reg <= 1'b0;
         ck_s2_reg <= 1'b0;
         ck_s3_reg <= 1'b0;
         tr_s1_reg <= 8'h00;
         tr_s2_reg <= 8'h00;
      end else begin
         in_s1_reg <= {ADAPTED_FRAME_START, ADAPTED_FRAME_DATA};
         in_s2_reg <= in_s1_reg;
         ck_s1_reg <= ADAPTED_FRAME_CLOCK;
         ck_s2_reg <= ck_s1_reg;
         ck_s3_reg <= ck_s2_reg;
         tr_s1_reg <= MGMT_TX_TRACE_ID;
         tr_s2_reg <= tr_s1_reg;
      end
   end

   // A rising edge of the link clock marks a byte to take.
   wire byte_stb = ck_s2_reg & ~ck_s3_reg;

   // ----------------------------------------------------------------
   // Frame position
   // ----------------------------------------------------------------

   rsfb_pkg::rsfb_pos_t pos_reg;
   rsfb_pkg::rsfb_pos_t pos_next;
   rsfb_pkg::rsfb_pos_t cur;

   // The start strobe forces the current byte to row 1, column 1.
   assign cur = in_s2_reg.start ? '0 : pos_reg;                   // [RQ17]

   // Count columns and rows; the frame wraps on its own as well.
   wire last_col = (cur.col == `RSFB_COLS - 11'h001);
   wire last_row = (cur.row == `RSFB_ROWS - 4'h1);
   assign pos_next.col = last_col ? 11'h000 : cur.col + 11'h001;
   assign pos_next.row = !last_col ? cur.row :
                         (last_row ? 4'h0 : cur.row + 4'h1);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pos_reg <= '0;
      end else if (byte_stb) begin
         pos_reg <= pos_next;
      end
   end

   // ----------------------------------------------------------------
   // Position decode
   // ----------------------------------------------------------------

   wire row1      = (cur.row == 4'h0);
   wire frame_1st = row1 && (cur.col == 11'h000);
   wire is_a1     = row1 && (cur.col < `RSFB_COL_A2);
   wire is_a2     = row1 && !is_a1 && (cur.col < `RSFB_COL_TRACE);
   wire is_trace  = row1 && (cur.col == `RSFB_COL_TRACE);
   wire is_rsv    = row1 && (cur.col >= `RSFB_COL_RSV)
                         && (cur.col < `RSFB_COL_OPER);
   wire is_oper   = row1 && (cur.col >= `RSFB_COL_OPER)
                         && (cur.col < `RSFB_COL_SCR);
   wire is_preset = row1 && (cur.col == `RSFB_COL_SCR);
   wire is_plain  = row1 && (cur.col < `RSFB_COL_SCR);
   wire is_parity = (cur.row == `RSFB_ROW_PARITY)
                 && (cur.col == `RSFB_COL_PARITY);
   wire is_chan   = ((cur.row == 4'h1) || (cur.row == 4'h2))
                 && ((cur.col == `RSFB_COL_PARITY && cur.row == 4'h2)
                     || cur.col == `RSFB_COL_ORDER
                     || cur.col == `RSFB_COL_USER);

   // ----------------------------------------------------------------
   // Overhead insertion
   // ----------------------------------------------------------------

   logic [7:0] bip_hold_reg;
   logic [7:0] bip_acc_reg;
   logic [7:0] pre_byte;

   // Build the byte before scrambling; undecoded bytes pass through.
   assign pre_byte =
      is_a1     ? `RSFB_FIRST_ALIGN  :                      // [RQ7] [RQ18]
      is_a2     ? `RSFB_SECOND_ALIGN :                      // [RQ7] [RQ18]
      is_trace  ? tr_s2_reg          :                      // [RQ8]
      is_rsv    ? `RSFB_FILL_BYTE    :                      // [RQ5]
      is_oper   ? `RSFB_FILL_BYTE    :                      // [RQ6]
      is_parity ? bip_hold_reg       :                      // [RQ10]
                  in_s2_reg.data;                           // [RQ3] [RQ4]

   // ----------------------------------------------------------------
   // Scrambler
   // ----------------------------------------------------------------

   logic [6:0] scr_reg;
   wire  [6:0] scr_start = is_preset ? `RSFB_SCR_PRESET : scr_reg;  // [RQ13]
   wire [14:0] scr_res   = scr_byte(scr_start, pre_byte);
   wire  [7:0] line_byte = is_plain ? pre_byte : scr_res[7:0];      // [RQ15]

   // The state only moves over scrambled bytes.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         scr_reg <= `RSFB_SCR_PRESET;
      end else if (byte_stb && !is_plain) begin
         scr_reg <= scr_res[14:8];                                // [RQ15]
      end
   end

   // ----------------------------------------------------------------
   // Parity over the scrambled frame
   // ----------------------------------------------------------------

   // Bytes XOR bitwise, so bit n is even parity of every bit n.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         bip_acc_reg  <= 8'h00;
         bip_hold_reg <= 8'h00;
      end else if (byte_stb) begin
         if (frame_1st) begin
            bip_hold_reg <= bip_acc_reg;                    // [RQ10] [RQ16]
            bip_acc_reg  <= line_byte;                      // [RQ9]
         end else begin
            bip_acc_reg  <= bip_acc_reg ^ line_byte;        // [RQ9] [RQ16]
         end
      end
   end

   // ----------------------------------------------------------------
   // Line output
   // ----------------------------------------------------------------

   logic [3:0] ck_dly_reg;

   // Data and start change one cycle after the taken edge.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         LINE_FRAME_DATA  <= 8'h00;
         LINE_FRAME_START <= 1'b0;
      end else if (byte_stb) begin
         LINE_FRAME_DATA  <= line_byte;                     // [RQ1]
         LINE_FRAME_START <= frame_1st;                     // [RQ19]
      end
   end

   // The output clock rises mid-byte, a fixed delay after the input.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ck_dly_reg       <= 4'h0;
         LINE_FRAME_CLOCK <= 1'b0;
      end else begin
         ck_dly_reg       <= {ck_dly_reg[2:0], ck_s3_reg};
         LINE_FRAME_CLOCK <= ck_dly_reg[3];                 // [RQ19] [RQ1]
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------

   // A taken byte at a given place in row one.
   sequence s_take_a1;
      byte_stb && is_a1;
   endsequence

   sequence s_take_a2;
      byte_stb && is_a2;
   endsequence

   a_first_align: assert property (                          // [RQ7] [RQ18]
      @(posedge CLK) disable iff (RST)
      s_take_a1 |=> LINE_FRAME_DATA == 8'hf6)
      else $error("First alignment byte wrong.");

   a_second_align: assert property (                         // [RQ7] [RQ18]
      @(posedge CLK) disable iff (RST)
      s_take_a2 |=> LINE_FRAME_DATA == 8'h28)
      else $error("Second alignment byte wrong.");

   a_trace_insert: assert property (                         // [RQ8]
      @(posedge CLK) disable iff (RST)
      byte_stb && is_trace |=> LINE_FRAME_DATA == $past(tr_s2_reg))
      else $error("Trace byte not from management input.");

   a_chan_pass: assert property (                            // [RQ3]
      @(posedge CLK) disable iff (RST)
      byte_stb && is_chan |=> LINE_FRAME_DATA
         == ($past(in_s2_reg.data) ^ $past(scr_res[7:0])
             ^ $past(pre_byte)))
      else $error("Channel byte altered.");

   a_plain_oh: assert property (                             // [RQ15] [RQ5] [RQ6]
      @(posedge CLK) disable iff (RST)
      byte_stb && (is_rsv || is_oper) |=> LINE_FRAME_DATA == 8'h55)
      else $error("Row-one overhead byte scrambled.");

   a_preset_ones: assert property (                          // [RQ13]
      @(posedge CLK) disable iff (RST)
      byte_stb && is_preset |=> LINE_FRAME_DATA[7]
         == ~$past(pre_byte[7]))
      else $error("Scrambler not preset at column 37.");

   a_parity_place: assert property (                         // [RQ10]
      @(posedge CLK) disable iff (RST)
      byte_stb && is_parity |-> pre_byte == bip_hold_reg)
      else $error("Parity byte not inserted.");

   a_parity_latch: assert property (                         // [RQ9] [RQ16]
      @(posedge CLK) disable iff (RST)
      byte_stb && frame_1st |=> bip_hold_reg == $past(bip_acc_reg)
         && bip_acc_reg == LINE_FRAME_DATA)
      else $error("Parity not taken from prior frame.");

   a_scr_step: assert property (                             // [RQ12] [RQ14]
      @(posedge CLK) disable iff (RST)
      byte_stb && !is_plain |=> LINE_FRAME_DATA[7]
         == ($past(pre_byte[7]) ^ $past(scr_start[6])))
      else $error("Scrambler output bit wrong.");

   // The clock flop turns high five edges after the take and is seen high one edge later.
   a_clock_latency: assert property (                        // [RQ19]
      @(posedge CLK) disable iff (RST)
      byte_stb |-> ##6 $rose(LINE_FRAME_CLOCK))
      else $error("Output clock latency wrong.");

   // A start strobe marks the byte it came with as the frame's first.
   sequence s_take_start;
      byte_stb && in_s2_reg.start;
   endsequence

   a_start_mark: assert property (                           // [RQ17] [RQ19]
      @(posedge CLK) disable iff (RST)
      s_take_start |=> LINE_FRAME_START)
      else $error("Frame start not marked on the output.");

   // Only the first byte of a frame carries the output start mark.
   a_start_only: assert property (                           // [RQ17]
      @(posedge CLK) disable iff (RST)
      byte_stb && !frame_1st |=> !LINE_FRAME_START)
      else $error("Output start mark on a later byte.");

   // The byte after a start strobe sits at row one, column two.
   a_pos_restart: assert property (                          // [RQ17]
      @(posedge CLK) disable iff (RST)
      s_take_start |=> pos_reg.row == 4'h0 && pos_reg.col == 11'h001)
      else $error("Position not restarted by the start strobe.");

   // Between taken bytes the output byte and start stand still.
   a_data_hold: assert property (                            // [RQ1]
      @(posedge CLK) disable iff (RST)
      !byte_stb |=> $stable(LINE_FRAME_DATA) && $stable(LINE_FRAME_START))
      else $error("Output byte changed between link bytes.");

   // The scrambler state does not move over the plain row-one bytes.
   a_scr_frozen: assert property (                           // [RQ15]
      @(posedge CLK) disable iff (RST)
      byte_stb && is_plain |=> $stable(scr_reg))
      else $error("Scrambler moved over an unscrambled byte.");

endmodule : rsfb_frame_source

// file: tb/rsfb_upstream_model.sv
// Upstream adaptation model: link byte clock, frame bytes and frame-start strobe.
module rsfb_upstream_model (
   input  wire logic  clk,
   input  wire logic  run,
   input  wire logic  restart,
   output logic       link_clk,
   output logic [7:0] link_data,
   output logic       link_start
);
   timeunit 1ns;
   timeprecision 1ns;
   integer      seed;
   integer      pos;
   logic [31:0] rnd;
   // ------------------------------------------------------------------
   // Byte launcher
   // ------------------------------------------------------------------
   // Launches each byte on the falling link edge and holds it a whole period.
   // The link clock stands still while run is low.
   initial begin
      seed       = 32'h4fc185ee;
      pos        = 0;
      link_clk   = 1'b0;
      link_data  = 8'h00;
      link_start = 1'b0;
      forever begin
         @(posedge clk);
         if (run) begin
            #1;
            rnd        = $random(seed);
            link_clk   = 1'b0;
            link_start = restart || pos == 0;
            pos        = link_start ? 1 : pos + 1;
            if (pos == 9720) pos = 0;
            link_data  = (pos % 61 == 5) ? 8'hff : (pos % 61 == 6) ? 8'h00 : rnd[7:0];
            repeat (4) @(posedge clk);
            #1 link_clk = 1'b1;
            repeat (3) @(posedge clk);
         end
      end
   end
endmodule : rsfb_upstream_model

// file: tb/test_rsfb_frame_source.sv
// Self-checking bench of the regenerator section frame source.
module test_rsfb_frame_source;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk;
   logic                 rst;
   logic                 run;
   logic                 restart;
   logic                 a_clk;
   logic [7:0]           a_data;
   logic                 a_start;
   logic [7:0]           trace;
   logic                 l_clk;
   logic [7:0]           l_data;
   logic                 l_start;
   integer               failures = 0;
   integer               checked = 0;
   integer               seed;
   integer               row;
   integer               col;
   logic [31:0]          rnd;
   logic [6:0]           scr;
   logic [7:0]           par_acc;
   logic [7:0]           par_hold;
   logic [7:0]           plain;
   logic [7:0]           sent;
   rsfb_pkg::rsfb_byte_t exp_q[$];
   time                  t_q[$];
   rsfb_pkg::rsfb_byte_t e;
   time                  t;
   // ------------------------------------------------------------------
   // Design, upstream model and clock
   // ------------------------------------------------------------------
   rsfb_frame_source dut (.CLK(clk), .RST(rst), .ADAPTED_FRAME_CLOCK(a_clk),
      .ADAPTED_FRAME_DATA(a_data), .ADAPTED_FRAME_START(a_start), .MGMT_TX_TRACE_ID(trace),
      .LINE_FRAME_CLOCK(l_clk), .LINE_FRAME_DATA(l_data), .LINE_FRAME_START(l_start));
   rsfb_upstream_model up (.clk(clk), .run(run), .restart(restart), .link_clk(a_clk),
      .link_data(a_data), .link_start(a_start));
   // The system clock runs at 10 MHz.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ------------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------------
   // Compares one value and counts the outcome.
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expd);
      checked++;
      if (seen !== expd) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, expd, seen);
      end
   endtask : check
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   // Scrambles one byte MSB first and advances the reference state.
   function automatic logic [7:0] scramble(input logic [7:0] d);
      logic [7:0] r;
      for (int b = 7; b >= 0; b--) begin
         r[b] = d[b] ^ scr[6];
         scr  = {scr[5:0], scr[6] ^ scr[5]};
      end
      return r;
   endfunction : scramble
   // ------------------------------------------------------------------
   // Reference model and monitor
   // ------------------------------------------------------------------
   // Works out the line byte expected for each byte taken from upstream.
   always @(posedge a_clk) begin
      if (a_start === 1'b1) begin
         row      = 0;
         col      = 0;
         par_hold = par_acc;
         par_acc  = 8'h00;
      end else begin
         col = (col == 1079) ? 0 : col + 1;
         if (col == 0) row = (row == 8) ? 0 : row + 1;
      end
      if (row == 0 && col < 12) plain = 8'hf6;
      else if (row == 0 && col < 24) plain = 8'h28;
      else if (row == 0 && col == 24) plain = trace;
      else if (row == 0 && col < 36) plain = 8'h55;
      else if (row == 1 && col == 0) plain = par_hold;
      else plain = a_data;
      if (row == 0 && col == 36) scr = 7'h7f;
      sent = (row == 0 && col < 36) ? plain : scramble(plain);
      par_acc = par_acc ^ sent;
      exp_q.push_back({a_start, sent});
      t_q.push_back($time);
   end
   // Checks each line byte at the rise of the line clock, which rises mid-byte.
   always @(posedge l_clk) begin
      if (exp_q.size() == 0) begin
         check("spare line byte", 8'h01, 8'h00);
      end else begin
         e = exp_q.pop_front();
         t = t_q.pop_front();
         check("line data", l_data, e.data);
         check("line start", {7'h00, l_start}, {7'h00, e.start});
         check("latency", {7'h00, ($time - t) > 650 && ($time - t) < 850}, 8'h01);
      end
   end
   // ------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------
   // Runs three frames; the first two are cut short by a fresh start strobe.
   initial begin
      seed     = 32'h4fc185ee;
      rst      = 1'b1;
      run      = 1'b0;
      restart  = 1'b0;
      trace    = 8'hff;
      row      = 0;
      col      = 0;
      scr      = 7'h7f;
      par_acc  = 8'h00;
      par_hold = 8'h00;
      repeat (3) @(posedge clk);
      check("reset data", l_data, 8'h00);
      #1 rst = 1'b0;
      repeat (2) @(posedge clk);
      #1 run = 1'b1;
      for (int i = 0; i < 3; i++) begin
         repeat (i == 1 ? 2200 : 1300) @(posedge a_clk);
         @(posedge clk);
         #1 restart = (i < 2);
         rnd = $random(seed);
         trace = rnd[7:0];
         @(posedge a_clk);
         @(posedge clk);
         #1 restart = 1'b0;
         run = (i < 2);
      end
      repeat (20) @(posedge clk);
      check("pending bytes", 8'(exp_q.size()), 8'h00);
      close_out();
   end
   // Cuts a hang short well after the expected run length.
   initial begin
      #5000000;
      failures++;
      close_out();
   end
endmodule : test_rsfb_frame_source
